// ### pkg/rdr_irq_pkg.sv
// Shared constants and types for the reader event status and clash position block.
// Assumes one 20 MHz clock; register offsets follow the reader's 5-bit register space.
package rdr_irq_pkg;

    // Clock and timing
    localparam int CLK_PERIOD_NS = 50;
    // No-response wait step, one unit of the wait register (plain default)
    localparam int NORESP_STEP_NS = 1000;
    localparam int NORESP_STEP_CYC = (NORESP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register address space
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam logic [4:0] PROTO_CTRL_ADDR = 5'h01;
    localparam logic [4:0] NORESP_WAIT_ADDR = 5'h07;
    localparam logic [4:0] EVENT_STATUS_ADDR = 5'h0C;
    localparam logic [4:0] CLASH_HI_EN_ADDR = 5'h0D;
    localparam logic [4:0] CLASH_LO_ADDR = 5'h0E;

    // Reset values
    localparam logic [7:0] EVENT_STATUS_RST = 8'h00;
    localparam logic [5:0] EVENT_ENABLE_RST = 6'h3E;
    localparam logic [7:0] CLASH_LO_RST = 8'h00;
    localparam logic [7:0] NORESP_WAIT_RST = 8'h00;
    localparam logic NO_RX_CRC_RST = 1'b0;

    // Event status bit positions
    localparam int TX_BIT = 7;
    localparam int SRX_BIT = 6;
    localparam int FIFO_BIT = 5;
    localparam int CRC_BIT = 4;
    localparam int PARITY_BIT = 3;
    localparam int FRAMING_BIT = 2;
    localparam int CLASH_BIT = 1;
    localparam int NORESP_BIT = 0;
    localparam int ENABLE_W = 6;

    // Bits that may change during each phase
    localparam logic [7:0] TX_PHASE_MASK = 8'hA0;
    localparam logic [7:0] RX_PHASE_MASK = 8'h40;
    // Transmit and receive-start sources have no enable bit
    localparam logic [1:0] PHASE_ALWAYS_ON = 2'h3;

    // Protocol control option bit that switches receive CRC checking off
    localparam int NO_RX_CRC_BIT = 7;

    // FIFO level thresholds in bits
    localparam int FIFO_CNT_W = 7;
    localparam logic [6:0] FIFO_HIGH_BITS = 7'h08;
    localparam logic [6:0] FIFO_LOW_BITS = 7'h04;

    // Clash position layout
    localparam int CLASH_POS_W = 10;
    localparam int CLASH_LO_W = 8;

    // Host register request from the serial or parallel port logic
    typedef struct packed {
        logic [4:0] addr;
        logic wr;
        logic rd;
        logic rd_end;
        logic [7:0] wdata;
    } reg_req_s;

    // Receive framer events, each a one-cycle pulse
    typedef struct packed {
        logic sof;
        logic crc_fail;
        logic parity_fail;
        logic framing_fail;
        logic clash;
        logic [9:0] err_pos;
    } rx_event_s;

    // No-response timer states
    typedef enum logic {
        WAIT_IDLE = 1'b0,
        WAIT_RUN = 1'b1
    } wait_state_e;

endpackage : rdr_irq_pkg

// ### rtl/noresp_timer.sv
// No-response timer: counts the wait value in steps after transmit ends.
// Assumes start, stop and clear come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module noresp_timer #(
    parameter int STEP_CYC = rdr_irq_pkg::NORESP_STEP_CYC,
    parameter int WAIT_W = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic clr_in,
    input wire logic [WAIT_W-1:0] wait_val_in,
    input wire logic start_in,
    input wire logic stop_in,
    // Result
    output logic expire_out
);
    localparam int STEP_W = $clog2(STEP_CYC + 1);

    if (STEP_CYC < 1) begin : g_bad_step
        $error("noresp_timer: STEP_CYC must be at least 1");
    end

    rdr_irq_pkg::wait_state_e st_r, st_nxt;
    logic [STEP_W-1:0] step_r, step_nxt;
    logic [WAIT_W-1:0] unit_r, unit_nxt;
    logic exp_r, exp_nxt;

    // A reply start ends the wait; a zero wait expires at once
    always_comb begin
        st_nxt = st_r;
        step_nxt = step_r;
        unit_nxt = unit_r;
        exp_nxt = 1'b0;
        unique case (st_r)
            rdr_irq_pkg::WAIT_IDLE: begin
                if (start_in) begin
                    st_nxt = rdr_irq_pkg::WAIT_RUN;
                    step_nxt = '0;
                    unit_nxt = wait_val_in;
                end
            end
            rdr_irq_pkg::WAIT_RUN: begin
                if (stop_in) begin
                    st_nxt = rdr_irq_pkg::WAIT_IDLE;
                end else if (unit_r == '0) begin
                    exp_nxt = 1'b1;
                    st_nxt = rdr_irq_pkg::WAIT_IDLE;
                end else if (step_r == STEP_W'(STEP_CYC - 1)) begin
                    step_nxt = '0;
                    unit_nxt = unit_r - 1'b1;
                end else begin
                    step_nxt = step_r + 1'b1;
                end
            end
        endcase
        if (clr_in) begin
            st_nxt = rdr_irq_pkg::WAIT_IDLE;
        end
    end

    // Timer registers
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            st_r <= rdr_irq_pkg::WAIT_IDLE;
            step_r <= '0;
            unit_r <= '0;
            exp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            step_r <= step_nxt;
            unit_r <= unit_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expire_out = exp_r;
endmodule : noresp_timer
`default_nettype wire

// ### rtl/clash_pos_capture.sv
// Error and clash bit position holder with separate read-clear of high and low parts.
// Assumes capture and clear strobes come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module clash_pos_capture #(
    parameter int POS_W = rdr_irq_pkg::CLASH_POS_W,
    parameter int LO_W = rdr_irq_pkg::CLASH_LO_W
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Capture and clear
    input wire logic clr_in,
    input wire logic cap_in,
    input wire logic [POS_W-1:0] pos_in,
    input wire logic clr_hi_in,
    input wire logic clr_lo_in,
    // Held position
    output logic [POS_W-1:0] pos_out
);
    if (POS_W <= LO_W) begin : g_bad_width
        $error("clash_pos_capture: POS_W must exceed LO_W");
    end

    logic [POS_W-1:0] pos_r, pos_nxt;

    // Capture after the read clears so a new position is never lost
    always_comb begin
        pos_nxt = pos_r;
        if (clr_hi_in) begin
            pos_nxt[POS_W-1:LO_W] = '0;
        end
        if (clr_lo_in) begin
            pos_nxt[LO_W-1:0] = '0;
        end
        if (cap_in) begin
            pos_nxt = pos_in;
        end
        if (clr_in) begin
            pos_nxt = '0;
        end
    end

    // Position register
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pos_r <= '0;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    assign pos_out = pos_r;
endmodule : clash_pos_capture
`default_nettype wire

// ### rtl/reader_irq_status_collision.sv
// Event status, event enable and clash position registers of the reader front end,
// driving one interrupt line towards the host.
// Assumes the host port logic delivers register requests on this clock and the
// framers and FIFO deliver phase levels and event pulses on this clock too.
// Contract
// - Reset, chip off or protocol write clears status
// - Status read clears flags and interrupt line
// - Transmit disables decoder; only transmit, FIFO flags
// - Receive changes only start flag; interrupt later
// - Transmit flag set at start, interrupt after
// - Receive-start flag at SOF, interrupt after reception
// - FIFO flag: above eight receiving, below four sending
// - CRC flag only when CRC checking enabled
// - Parity flag bit three, framing bit two
// - Clash flag bit one on subcarrier collision
// - No-response flag when wait time expires
// - Enable register resets to all but no-response
// - Enable register top bits hold position high
// - Position high bits clear after enable read
// - Low position register clears after read
// - Position captures any reception error position
`timescale 1ns/1ps
`default_nettype none
module reader_irq_status_collision #(
    parameter int NORESP_STEP_CYC = rdr_irq_pkg::NORESP_STEP_CYC
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Chip enable pin, asynchronous to the clock
    input wire logic chip_en_in,
    // Host register access
    input wire rdr_irq_pkg::reg_req_s reg_req_in,
    output logic [rdr_irq_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_hit_out,
    // Phase levels and events from the framers and FIFO
    input wire logic tx_active_in,
    input wire logic rx_active_in,
    input wire logic [rdr_irq_pkg::FIFO_CNT_W-1:0] fifo_bits_in,
    input wire rdr_irq_pkg::rx_event_s rx_event_in,
    // Towards host and receiver
    output logic irq_out,
    output logic rx_decoder_en_out
);
    if (NORESP_STEP_CYC < 1) begin : g_bad_step
        $error("reader_irq_status_collision: NORESP_STEP_CYC must be at least 1");
    end

    // Chip enable synchroniser
    logic ce_meta_r;
    logic ce_sync_r;
    logic chip_off;

    // Phase edge tracking
    logic tx_prev_r, tx_prev_nxt;
    logic rx_prev_r, rx_prev_nxt;
    logic fifo_prev_r, fifo_prev_nxt;
    logic tx_start, tx_end, rx_start, rx_end;
    logic fifo_cond, fifo_rise;

    // Register decode
    logic wr_proto, wr_wait, wr_enable;
    logic rd_done, clr_status, clr_hi, clr_lo;

    // Register state
    logic [7:0] status_r, status_nxt;
    logic [7:0] pend_r, pend_nxt;
    logic [rdr_irq_pkg::ENABLE_W-1:0] enable_r, enable_nxt;
    logic no_rx_crc_r, no_rx_crc_nxt;
    logic [7:0] wait_r, wait_nxt;
    logic irq_r, irq_nxt;
    logic dec_en_r, dec_en_nxt;

    // Read path state
    logic [rdr_irq_pkg::ADDR_W-1:0] rd_addr_r, rd_addr_nxt;
    logic rd_pend_r, rd_pend_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic hit_r, hit_nxt;

    // Event sources
    logic [7:0] ev_set;
    logic [7:0] direct_set;
    logic [7:0] en_vec;
    logic crc_ok_fail;
    logic noresp_expire;
    logic pos_cap;
    logic [rdr_irq_pkg::CLASH_POS_W-1:0] clash_pos;
    logic raise;

    // Two flops before anything reads the pin
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ce_meta_r <= 1'b0;
            ce_sync_r <= 1'b0;
        end else begin
            ce_meta_r <= chip_en_in;
            ce_sync_r <= ce_meta_r;
        end
    end

    // Chip off acts like a held reset of the register state
    assign chip_off = ~ce_sync_r;

    // Phase edges and FIFO level condition
    assign tx_start = tx_active_in & ~tx_prev_r;
    assign tx_end = ~tx_active_in & tx_prev_r;
    assign rx_start = rx_active_in & ~rx_prev_r;
    assign rx_end = ~rx_active_in & rx_prev_r;
    assign fifo_cond = (rx_active_in & (fifo_bits_in > rdr_irq_pkg::FIFO_HIGH_BITS))
                     | (tx_active_in & (fifo_bits_in < rdr_irq_pkg::FIFO_LOW_BITS));
    // Edge only, so a level that stays put does not refire after a read
    assign fifo_rise = fifo_cond & ~fifo_prev_r;

    always_comb begin
        tx_prev_nxt = tx_active_in;
        rx_prev_nxt = rx_active_in;
        fifo_prev_nxt = fifo_cond;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            tx_prev_r <= 1'b0;
            rx_prev_r <= 1'b0;
            fifo_prev_r <= 1'b0;
        end else begin
            tx_prev_r <= tx_prev_nxt;
            rx_prev_r <= rx_prev_nxt;
            fifo_prev_r <= fifo_prev_nxt;
        end
    end

    // Write decode; the protocol and wait registers live elsewhere, we only snoop
    assign wr_proto = reg_req_in.wr && (reg_req_in.addr == rdr_irq_pkg::PROTO_CTRL_ADDR);
    assign wr_wait = reg_req_in.wr && (reg_req_in.addr == rdr_irq_pkg::NORESP_WAIT_ADDR);
    assign wr_enable = reg_req_in.wr && (reg_req_in.addr == rdr_irq_pkg::CLASH_HI_EN_ADDR);

    // Clears take effect when the read phase ends, not when data is fetched
    assign rd_done = reg_req_in.rd_end & rd_pend_r;
    assign clr_status = rd_done && (rd_addr_r == rdr_irq_pkg::EVENT_STATUS_ADDR);
    assign clr_hi = rd_done && (rd_addr_r == rdr_irq_pkg::CLASH_HI_EN_ADDR);
    assign clr_lo = rd_done && (rd_addr_r == rdr_irq_pkg::CLASH_LO_ADDR);

    // CRC failures count only while checking is on
    assign crc_ok_fail = rx_event_in.crc_fail & ~no_rx_crc_r;

    // Raw event pulses in status bit order
    always_comb begin
        ev_set = '0;
        ev_set[rdr_irq_pkg::TX_BIT] = tx_start;
        ev_set[rdr_irq_pkg::SRX_BIT] = rx_event_in.sof;
        ev_set[rdr_irq_pkg::FIFO_BIT] = fifo_rise;
        ev_set[rdr_irq_pkg::CRC_BIT] = crc_ok_fail;
        ev_set[rdr_irq_pkg::PARITY_BIT] = rx_event_in.parity_fail;
        ev_set[rdr_irq_pkg::FRAMING_BIT] = rx_event_in.framing_fail;
        ev_set[rdr_irq_pkg::CLASH_BIT] = rx_event_in.clash;
        ev_set[rdr_irq_pkg::NORESP_BIT] = noresp_expire;
    end

    // Phase filter: receive-time errors wait in pend_r until reception ends
    always_comb begin
        pend_nxt = pend_r;
        if (tx_active_in) begin
            direct_set = ev_set & rdr_irq_pkg::TX_PHASE_MASK;
        end else if (rx_active_in) begin
            direct_set = ev_set & rdr_irq_pkg::RX_PHASE_MASK;
            pend_nxt = pend_r | (ev_set & ~rdr_irq_pkg::RX_PHASE_MASK);
        end else begin
            direct_set = ev_set;
        end
        if (rx_end) begin
            direct_set = direct_set | pend_r;
            pend_nxt = '0;
        end
        if (chip_off || wr_proto) begin
            pend_nxt = '0;
        end
    end

    // Status flags: a new event wins over the read clear in the same cycle
    always_comb begin
        status_nxt = (status_r & ~{8{clr_status}}) | direct_set;
        if (chip_off || wr_proto) begin
            status_nxt = rdr_irq_pkg::EVENT_STATUS_RST;
        end
    end

    // Enable mask, snooped option bits
    always_comb begin
        enable_nxt = enable_r;
        no_rx_crc_nxt = no_rx_crc_r;
        wait_nxt = wait_r;
        if (wr_enable) begin
            enable_nxt = reg_req_in.wdata[rdr_irq_pkg::ENABLE_W-1:0];
        end
        if (wr_proto) begin
            no_rx_crc_nxt = reg_req_in.wdata[rdr_irq_pkg::NO_RX_CRC_BIT];
        end
        if (wr_wait) begin
            wait_nxt = reg_req_in.wdata;
        end
        if (chip_off) begin
            enable_nxt = rdr_irq_pkg::EVENT_ENABLE_RST;
            no_rx_crc_nxt = rdr_irq_pkg::NO_RX_CRC_RST;
            wait_nxt = rdr_irq_pkg::NORESP_WAIT_RST;
        end
    end

    // Interrupt: raised only between phases, held until the status read ends
    assign en_vec = {rdr_irq_pkg::PHASE_ALWAYS_ON, enable_r};
    assign raise = ~tx_active_in & ~rx_active_in & (|(status_nxt & en_vec));

    always_comb begin
        irq_nxt = raise | (irq_r & ~clr_status);
        if (chip_off || wr_proto) begin
            irq_nxt = 1'b0;
        end
    end

    // Receive decoder is held off from one cycle after transmit starts until one cycle after it ends
    always_comb begin
        dec_en_nxt = ~tx_active_in & ce_sync_r;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            status_r <= rdr_irq_pkg::EVENT_STATUS_RST;
            pend_r <= '0;
            enable_r <= rdr_irq_pkg::EVENT_ENABLE_RST;
            no_rx_crc_r <= rdr_irq_pkg::NO_RX_CRC_RST;
            wait_r <= rdr_irq_pkg::NORESP_WAIT_RST;
            irq_r <= 1'b0;
            dec_en_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            pend_r <= pend_nxt;
            enable_r <= enable_nxt;
            no_rx_crc_r <= no_rx_crc_nxt;
            wait_r <= wait_nxt;
            irq_r <= irq_nxt;
            dec_en_r <= dec_en_nxt;
        end
    end

    // No-response wait runs from end of transmit until a reply starts
    noresp_timer #(
        .STEP_CYC(NORESP_STEP_CYC),
        .WAIT_W(8)
    ) u_noresp_timer (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(chip_off),
        .wait_val_in(wait_r),
        .start_in(tx_end),
        .stop_in(rx_event_in.sof | rx_start),
        .expire_out(noresp_expire)
    );

    // Any reception error records its position; none while sending, the decoder is off
    assign pos_cap = ~tx_active_in & (crc_ok_fail | rx_event_in.parity_fail
                   | rx_event_in.framing_fail | rx_event_in.clash);

    clash_pos_capture #(
        .POS_W(rdr_irq_pkg::CLASH_POS_W),
        .LO_W(rdr_irq_pkg::CLASH_LO_W)
    ) u_clash_pos (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .clr_in(chip_off),
        .cap_in(pos_cap),
        .pos_in(rx_event_in.err_pos),
        .clr_hi_in(clr_hi),
        .clr_lo_in(clr_lo),
        .pos_out(clash_pos)
    );

    // Read fetch: data is sampled at the read strobe, the clear waits for rd_end
    always_comb begin
        rd_addr_nxt = rd_addr_r;
        rd_pend_nxt = rd_pend_r & ~reg_req_in.rd_end;
        rdata_nxt = rdata_r;
        hit_nxt = 1'b0;
        if (reg_req_in.rd) begin
            rd_addr_nxt = reg_req_in.addr;
            rd_pend_nxt = 1'b1;
            hit_nxt = 1'b1;
            unique case (reg_req_in.addr)
                rdr_irq_pkg::EVENT_STATUS_ADDR: begin
                    rdata_nxt = status_r;
                end
                rdr_irq_pkg::CLASH_HI_EN_ADDR: begin
                    rdata_nxt = {clash_pos[rdr_irq_pkg::CLASH_POS_W-1:rdr_irq_pkg::CLASH_LO_W],
                                 enable_r};
                end
                rdr_irq_pkg::CLASH_LO_ADDR: begin
                    rdata_nxt = clash_pos[rdr_irq_pkg::CLASH_LO_W-1:0];
                end
                default: begin
                    // Other addresses belong to other blocks
                    rdata_nxt = 8'h00;
                    hit_nxt = 1'b0;
                end
            endcase
        end
        if (chip_off) begin
            rd_pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rd_addr_r <= '0;
            rd_pend_r <= 1'b0;
            rdata_r <= 8'h00;
            hit_r <= 1'b0;
        end else begin
            rd_addr_r <= rd_addr_nxt;
            rd_pend_r <= rd_pend_nxt;
            rdata_r <= rdata_nxt;
            hit_r <= hit_nxt;
        end
    end

    // Outputs, all from flops
    assign reg_rdata_out = rdata_r;
    assign reg_hit_out = hit_r;
    assign irq_out = irq_r;
    assign rx_decoder_en_out = dec_en_r;
endmodule : reader_irq_status_collision
`default_nettype wire

// ### tb/rdr_irq_chk.sv
// Checker: interrupt timing, read clear, reset and bus answers.
// Sees only the top module's ports; bound to it below.
`timescale 1ns/1ps
`default_nettype none
module rdr_irq_chk (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    // Watched inputs
    input wire logic chip_en_in,
    input wire rdr_irq_pkg::reg_req_s reg_req_in,
    input wire logic tx_active_in,
    input wire logic rx_active_in,
    input wire rdr_irq_pkg::rx_event_s rx_event_in,
    // Watched outputs
    input wire logic [rdr_irq_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic reg_hit_out,
    input wire logic irq_out,
    input wire logic rx_decoder_en_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // Quiet: both phases idle and no framer event pulse this cycle
    wire logic st_rd = reg_req_in.rd && reg_req_in.addr == 5'h0C;
    wire logic mapped = reg_req_in.addr inside {[5'h0C:5'h0E]};
    wire logic proto_wr = reg_req_in.wr && reg_req_in.addr == 5'h01;
    wire logic quiet = !tx_active_in && !rx_active_in && rx_event_in[14:10] == 5'h00;

    a_rst_quiet: assert property ($fell(sys_rst_in) |-> !irq_out && !reg_hit_out)
        else $error("outputs busy after reset");
    a_proto_clear: assert property (proto_wr |=> !irq_out)
        else $error("interrupt kept after protocol write");
    a_idle_only: assert property ((tx_active_in || rx_active_in) && !irq_out |=> !irq_out)
        else $error("interrupt raised inside a phase");
    a_tx_end_irq: assert property ($fell(tx_active_in) && !rx_active_in
        && $past(tx_active_in, 2) |=> irq_out)
        else $error("no interrupt after transmit end");
    a_read_clear: assert property ($past(st_rd, 2) && reg_req_in.rd_end && quiet
        && !reg_req_in.wr |=> !irq_out)
        else $error("status read left interrupt high");
    a_irq_hold: assert property (irq_out && !reg_req_in.rd_end && !proto_wr && chip_en_in
        && $past(chip_en_in) && $past(chip_en_in, 2) |=> irq_out)
        else $error("interrupt dropped without read");
    a_dec_tx: assert property (tx_active_in |=> !rx_decoder_en_out)
        else $error("decoder enabled while sending");
    a_hit_map: assert property (reg_req_in.rd && mapped |=> reg_hit_out)
        else $error("no hit on mapped read");
    a_unmap_zero: assert property (reg_req_in.rd && !mapped |=>
        reg_rdata_out == 8'h00 && !reg_hit_out)
        else $error("unmapped read answered");

    // Main scenarios seen
    c_irq_rise: cover property ($rose(irq_out));
    c_status_read: cover property (st_rd ##1 reg_hit_out);
    c_rx_error: cover property (rx_active_in && rx_event_in[13:10] != 4'h0);
    c_chip_off: cover property (!chip_en_in);
endmodule : rdr_irq_chk

bind reader_irq_status_collision rdr_irq_chk u_chk (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .chip_en_in(chip_en_in),
    .reg_req_in(reg_req_in), .tx_active_in(tx_active_in), .rx_active_in(rx_active_in),
    .rx_event_in(rx_event_in), .reg_rdata_out(reg_rdata_out),
    .reg_hit_out(reg_hit_out), .irq_out(irq_out), .rx_decoder_en_out(rx_decoder_en_out));
`default_nettype wire

// ### tb/host_port_model.sv
// Host model: writes and reads registers through the block's request port.
// Assumes the bench calls its tasks; gap makes a slow host end reads later.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
    // Clock
    input wire logic ref_clk_in,
    // Requests towards the block
    output var rdr_irq_pkg::reg_req_s reg_req_out,
    // Answers
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_hit_in
);
    int gap = 0;
    initial reg_req_out = '0;
    // One-cycle write strobe with address and data
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_req_out.wr <= 1'b1;
        reg_req_out.addr <= a;
        reg_req_out.wdata <= d;
        @(posedge ref_clk_in);
        reg_req_out.wr <= 1'b0;
    endtask : wr
    // Read, take data and hit the cycle after the strobe, then end the phase
    task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic h);
        @(posedge ref_clk_in);
        reg_req_out.rd <= 1'b1;
        reg_req_out.addr <= a;
        @(posedge ref_clk_in);
        reg_req_out.rd <= 1'b0;
        #1;
        d = reg_rdata_in;
        h = reg_hit_in;
        repeat (gap) @(posedge ref_clk_in);
        @(posedge ref_clk_in);
        reg_req_out.rd_end <= 1'b1;
        @(posedge ref_clk_in);
        reg_req_out.rd_end <= 1'b0;
    endtask : rd
endmodule : host_port_model
`default_nettype wire

// ### tb/tb_reader_irq_status_collision.sv
// Bench: drives phases and framer events, reads back through the host model.
// Assumes the bound checker; a register model gives every read data expectation.
`timescale 1ns/1ps
`default_nettype none
module tb_reader_irq_status_collision;
    localparam int STEP = 2;
    logic ref_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic chip_en = 1'b1;
    logic tx = 1'b0;
    logic rx = 1'b0;
    logic [6:0] fifo = 7'h00;
    rdr_irq_pkg::rx_event_s ev = '0;
    rdr_irq_pkg::reg_req_s req;
    logic [7:0] rdata, d;
    logic [9:0] p;
    logic hit, irq, dec_en, h;
    int n_fail = 0;
    int comparisons = 0;
    int st_m = 0;
    int en_m = 'h3E;
    int pos_m = 0;

    reader_irq_status_collision #(.NORESP_STEP_CYC(STEP)) dut (.ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in), .chip_en_in(chip_en), .reg_req_in(req), .reg_rdata_out(rdata),
        .reg_hit_out(hit), .tx_active_in(tx), .rx_active_in(rx), .fifo_bits_in(fifo),
        .rx_event_in(ev), .irq_out(irq), .rx_decoder_en_out(dec_en));
    host_port_model host (.ref_clk_in(ref_clk_in), .reg_req_out(req), .reg_rdata_in(rdata),
        .reg_hit_in(hit));

    // 20 MHz clock
    always #25 ref_clk_in = ~ref_clk_in;

    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results
    // Read via the host, compare with the model, then apply read clears
    task automatic rd_chk(input logic [4:0] a);
        logic [7:0] e;
        case (a)
            5'h0C: e = 8'(st_m);
            5'h0D: e = {pos_m[9:8], en_m[5:0]};
            5'h0E: e = pos_m[7:0];
            default: e = 8'h00;
        endcase
        host.rd(a, d, h);
        chk("read data", e, d);
        chk("read hit", 8'(a inside {[5'h0C:5'h0E]}), 8'(h));
        if (a == 5'h0C) st_m = 0;
        if (a == 5'h0D) pos_m &= 'hFF;
        if (a == 5'h0E) pos_m &= 'h300;
        #1;
        if (a == 5'h0C) chk("irq after read", 8'h00, 8'(irq));
    endtask : rd_chk
    // Bounded wait for the interrupt; a hang ends the run
    task automatic wait_irq();
        int k = 0;
        while (irq !== 1'b1 && k < 100) begin
            @(posedge ref_clk_in);
            #1;
            k++;
        end
        chk("irq raised", 8'h01, 8'(irq));
        if (irq !== 1'b1) results();
    endtask : wait_irq
    // Transmit phase; a mid-phase framer pulse must be dropped
    task automatic tx_phase(input logic [6:0] fb, input rdr_irq_pkg::rx_event_s e);
        @(posedge ref_clk_in);
        tx <= 1'b1;
        fifo <= fb;
        repeat (2) @(posedge ref_clk_in);
        ev <= e;
        @(posedge ref_clk_in);
        ev <= '0;
        repeat (2) @(posedge ref_clk_in);
        tx <= 1'b0;
        st_m |= (fb < 7'h04) ? 'hA0 : 'h80;
    endtask : tx_phase

    initial begin
        void'($urandom(57));
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        for (int j = 12; j < 16; j++) begin
            rd_chk(5'(j));
        end
        $display("test reset values done");
        // Transmit; masked wait expiry is recorded, no own interrupt
        host.wr(5'h07, 8'h03);
        tx_phase(7'h02, {5'h04, 10'h3FF});
        wait_irq();
        repeat (3 * STEP + 12) @(posedge ref_clk_in);
        st_m |= 'h01;
        host.gap = 2;
        rd_chk(5'h0C);
        host.gap = 0;
        rd_chk(5'h0E);
        $display("test transmit done");
        // One reception per error kind; last pass with CRC check off
        host.wr(5'h07, 8'h0A);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) host.wr(5'h01, 8'h80);
            p = 10'($urandom);
            tx_phase(7'h06, '0);
            wait_irq();
            rd_chk(5'h0C);
            @(posedge ref_clk_in);
            rx <= 1'b1;
            fifo <= 7'(9 + $urandom % 4);
            ev <= {1'b1, 14'h0000};
            @(posedge ref_clk_in);
            ev <= '0;
            @(posedge ref_clk_in);
            ev <= {1'b0, 4'(4'h8 >> (i % 4)), p};
            @(posedge ref_clk_in);
            ev <= '0;
            repeat (2) @(posedge ref_clk_in);
            #1;
            chk("irq in receive", 8'h00, 8'(irq));
            @(posedge ref_clk_in);
            rx <= 1'b0;
            fifo <= 7'h00;
            st_m |= 'h60;
            if (i < 4) st_m |= 'h10 >> i;
            if (i < 4) pos_m = int'(p);
            wait_irq();
            for (int j = 0; j < 5; j++) begin
                rd_chk(5'(j < 3 ? 12 + j : 10 + j));
            end
        end
        $display("test receive errors done");
        // Protocol write clears flags; chip off restores defaults
        tx_phase(7'h06, '0);
        wait_irq();
        host.wr(5'h01, 8'h00);
        st_m = 0;
        rd_chk(5'h0C);
        host.wr(5'h0D, 8'hC1);
        en_m = 'h01;
        rd_chk(5'h0D);
        tx_phase(7'h06, '0);
        wait_irq();
        chip_en <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        chip_en <= 1'b1;
        repeat (4) @(negedge ref_clk_in);
        st_m = 0;
        en_m = 'h3E;
        chk("irq after chip off", 8'h00, 8'(irq));
        rd_chk(5'h0C);
        rd_chk(5'h0D);
        $display("test clears done");
        results();
    end
endmodule : tb_reader_irq_status_collision
`default_nettype wire
